// ==== adc_seq_pkg.sv ====
// constants for the converter sequencer: timing counts, control word layout
// assumes a 100 MHz system clock and a master conversion clock derived from it
package adc_seq_pkg;
    // clock rates, as periods in ns
    localparam int CLK_PERIOD_NS = 10;
    localparam int MCLK_PERIOD_NS = 250;
    localparam int MCLK_DIV = MCLK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [4:0] MCLK_DIV_LAST = 5'(MCLK_DIV - 1);

    // sequence lengths in master clock periods
    localparam logic [16:0] CONV_MCLK = 17'h00012;
    localparam int CAL_FULL_MCLK = 125013;
    localparam int CAL_DAC_FS_MCLK = 111124;
    localparam int CAL_OFFSET_MCLK = 13889;

    // result valid before busy falls: half a master period, least, rounded up
    localparam int HALF_MCLK_NS = MCLK_PERIOD_NS / 2;
    localparam int HALF_CYC = (HALF_MCLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] HALF_CYC_LAST = 5'(HALF_CYC - 1);
    // busy rise after chip select rises: 2.5 master periods, longest, rounded down
    localparam int BUSY_RISE_NS = (MCLK_PERIOD_NS * 5) / 2;
    localparam int BUSY_RISE_CYC = BUSY_RISE_NS / CLK_PERIOD_NS;

    // control word written over the data bus
    localparam int CTL_CHAN_LSB = 0;
    localparam int CTL_CAL_LSB = 3;
    localparam int CTL_CAL_GO = 5;

    // result word layout in the fifo
    localparam int RES_WIDTH = 16;
    localparam int RES_DEPTH = 16;
    localparam logic [11:0] OFFSET_RST = 12'h000;

    typedef enum logic [1:0] {
        CAL_NONE = 2'h0,
        CAL_FULL = 2'h1,
        CAL_DAC_FS = 2'h2,
        CAL_OFFSET = 2'h3
    } cal_kind_t;
endpackage

// ==== result_fifo.sv ====
// result buffer between the converter and the parallel read port
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic [AW:0] nxt_wr_ptr;
    logic [AW:0] nxt_rd_ptr;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = !((wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]));
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

    always_comb
    begin
        nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
        nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
    end

    // storage has no reset; only the pointers need a defined start
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
        if (sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
        end
    end
endmodule
`default_nettype wire

// ==== adc_sequencer.sv ====
// conversion and calibration sequencer with a parallel host port
// assumes pins arrive asynchronously and adc_code comes from on-chip logic
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - a conversion finishes exactly 18 master clock periods after it starts
// - full self-calibration keeps the device busy for 125013 master periods
// - dac plus system full-scale calibration takes 111124 master periods
// - offset calibration takes 13889 periods, then corrects every later result
// - busy rises within 2.5 master periods of chip select rising for calibration
// - new result sits in the result buffer half a period before busy falls
module adc_sequencer
    import adc_seq_pkg::*;
#(
    parameter logic [16:0] CAL_FULL_LEN = 17'(CAL_FULL_MCLK),
    parameter logic [16:0] CAL_DAC_FS_LEN = 17'(CAL_DAC_FS_MCLK),
    parameter logic [16:0] CAL_OFFSET_LEN = 17'(CAL_OFFSET_MCLK)
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sample_trigger_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic upper_byte_select,
    input wire logic [15:0] db_in,
    output logic [15:0] db_out,
    output logic db_oe_n,
    output logic busy,
    output logic [2:0] channel_select,
    input wire logic [11:0] adc_code
);
    typedef enum {ST_IDLE, ST_CONV, ST_CAL, ST_SETTLE} seq_state_t;

    // pin synchronisers: trigger, cs, rd, wr, byte select, then data bus
    logic [20:0] pin_meta_ff;
    logic [20:0] pin_sync_ff;
    logic [20:0] pin_prev_ff;
    logic trig_s;
    logic cs_s;
    logic rd_s;
    logic wr_s;
    logic ubs_s;
    logic [15:0] db_s;

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            pin_meta_ff <= 21'h00000f;
            pin_sync_ff <= 21'h00000f;
            pin_prev_ff <= 21'h00000f;
        end
        else
        begin
            pin_meta_ff <= {db_in, upper_byte_select, wr_n, rd_n, cs_n, sample_trigger_n};
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    assign trig_s = pin_sync_ff[0];
    assign cs_s = pin_sync_ff[1];
    assign rd_s = pin_sync_ff[2];
    assign wr_s = pin_sync_ff[3];
    assign ubs_s = pin_sync_ff[4];
    assign db_s = pin_sync_ff[20:5];

    // edge events on the synchronised pins
    logic trig_fall;
    logic cs_rise;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    assign trig_fall = pin_prev_ff[0] && !trig_s;
    assign cs_rise = !pin_prev_ff[1] && cs_s;
    assign rd_fall = pin_prev_ff[2] && !rd_s && !cs_s;
    assign rd_rise = !pin_prev_ff[2] && rd_s;
    assign wr_rise = !pin_prev_ff[3] && wr_s && !cs_s;

    // control word: channel, calibration kind and pending start
    logic [2:0] chan_ff;
    logic [2:0] nxt_chan;
    cal_kind_t cal_kind_ff;
    cal_kind_t nxt_cal_kind;
    logic cal_pend_ff;
    logic nxt_cal_pend;
    logic cal_start;

    // calibration only launches on cs rising, so the host can finish its write
    assign cal_start = cal_pend_ff && cs_rise;

    always_comb
    begin
        nxt_chan = chan_ff;
        nxt_cal_kind = cal_kind_ff;
        nxt_cal_pend = cal_pend_ff;
        if (cal_start)
        begin
            nxt_cal_pend = 1'b0;
        end
        if (wr_rise)
        begin
            nxt_chan = db_s[CTL_CHAN_LSB +: 3];
            nxt_cal_kind = cal_kind_t'(db_s[CTL_CAL_LSB +: 2]);
            nxt_cal_pend = db_s[CTL_CAL_GO] && (db_s[CTL_CAL_LSB +: 2] != 2'h0);
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            chan_ff <= 3'h0;
            cal_kind_ff <= CAL_NONE;
            cal_pend_ff <= 1'b0;
        end
        else
        begin
            chan_ff <= nxt_chan;
            cal_kind_ff <= nxt_cal_kind;
            cal_pend_ff <= nxt_cal_pend;
        end
    end

    assign channel_select = chan_ff;

    // sequence state, master clock divider and period counter
    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic [4:0] div_ff;
    logic [4:0] nxt_div;
    logic [16:0] per_ff;
    logic [16:0] nxt_per;
    logic [16:0] len_ff;
    logic [16:0] nxt_len;
    logic [4:0] settle_ff;
    logic [4:0] nxt_settle;
    logic [11:0] offset_ff;
    logic [11:0] nxt_offset;
    logic busy_ff;
    logic nxt_busy;
    logic mclk_tick;
    logic res_valid;
    logic res_ready;
    logic [15:0] res_data;
    logic conv_start;

    // divider restarts with each sequence so period counts line up exactly
    assign mclk_tick = (div_ff == MCLK_DIV_LAST);
    // no new conversion while the buffer is full: back-pressure stalls sampling
    assign conv_start = trig_fall && res_ready;

    // offset correction applies to every result after an offset calibration
    assign res_data = {1'b0, chan_ff, adc_code - offset_ff};
    assign res_valid = (state_ff == ST_CONV) && mclk_tick && (per_ff == CONV_MCLK - 17'h1);

    function automatic logic [16:0] cal_length(input cal_kind_t kind);
        unique case (kind)
            CAL_FULL: cal_length = CAL_FULL_LEN;
            CAL_DAC_FS: cal_length = CAL_DAC_FS_LEN;
            CAL_OFFSET: cal_length = CAL_OFFSET_LEN;
            CAL_NONE: cal_length = 17'h00001;
        endcase
    endfunction

    always_comb
    begin
        nxt_state = state_ff;
        nxt_div = mclk_tick ? 5'h00 : div_ff + 5'h01;
        nxt_per = mclk_tick ? per_ff + 17'h1 : per_ff;
        nxt_len = len_ff;
        nxt_settle = settle_ff;
        nxt_offset = offset_ff;
        nxt_busy = busy_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                nxt_div = 5'h00;
                nxt_per = 17'h0;
                if (cal_start)
                begin
                    nxt_state = ST_CAL;
                    nxt_len = cal_length(cal_kind_ff);
                    nxt_busy = 1'b1;
                end
                else if (conv_start)
                begin
                    nxt_state = ST_CONV;
                    nxt_busy = 1'b1;
                end
            end
            ST_CONV:
            begin
                // result goes into the buffer on the 18th period
                if (res_valid)
                begin
                    nxt_state = ST_SETTLE;
                    nxt_settle = 5'h00;
                end
            end
            ST_CAL:
            begin
                if (mclk_tick && (per_ff == len_ff - 17'h1))
                begin
                    nxt_state = ST_IDLE;
                    nxt_busy = 1'b0;
                    if (cal_kind_ff == CAL_OFFSET)
                    begin
                        nxt_offset = adc_code;
                    end
                end
            end
            ST_SETTLE:
            begin
                // busy holds a half master period after the result lands
                nxt_settle = settle_ff + 5'h01;
                if (settle_ff == HALF_CYC_LAST)
                begin
                    nxt_state = ST_IDLE;
                    nxt_busy = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state_ff <= ST_IDLE;
            div_ff <= 5'h00;
            per_ff <= 17'h0;
            len_ff <= 17'h0;
            settle_ff <= 5'h00;
            offset_ff <= OFFSET_RST;
            busy_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            div_ff <= nxt_div;
            per_ff <= nxt_per;
            len_ff <= nxt_len;
            settle_ff <= nxt_settle;
            offset_ff <= nxt_offset;
            busy_ff <= nxt_busy;
        end
    end

    assign busy = busy_ff;

    // result buffer; the read port pops one word per low byte read strobe
    logic head_valid;
    logic [15:0] head_data;
    logic pop;

    result_fifo #(
        .WIDTH(RES_WIDTH),
        .DEPTH(RES_DEPTH)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data(res_data),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head_data)
    );

    // read port: drive on rd fall, pop on rd rise only for the low byte read
    logic [15:0] dout_ff;
    logic [15:0] nxt_dout;
    logic oe_n_ff;
    logic nxt_oe_n;
    assign pop = rd_rise && !oe_n_ff && head_valid && !pin_prev_ff[4];

    always_comb
    begin
        nxt_dout = dout_ff;
        nxt_oe_n = oe_n_ff;
        if (rd_fall)
        begin
            nxt_oe_n = 1'b0;
            nxt_dout = ubs_s ? {8'h00, head_data[15:8]} : head_data;
        end
        else if (rd_s || cs_s)
        begin
            nxt_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            dout_ff <= 16'h0000;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            dout_ff <= nxt_dout;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign db_out = dout_ff;
    assign db_oe_n = oe_n_ff;

    // helper: cycles since busy rose, for length checks
    logic [21:0] busy_len_ff;
    always_ff @(posedge clock)
    begin
        if (sys_rst || !busy_ff)
        begin
            busy_len_ff <= 22'h0;
        end
        else
        begin
            busy_len_ff <= busy_len_ff + 22'h1;
        end
    end

    localparam int CONV_CYC = 18 * MCLK_DIV;

    a_conv_length: assert property (@(posedge clock) disable iff (sys_rst)
        res_valid |-> busy_len_ff == 22'(CONV_CYC - 1))
        else $error("conversion result not at 18 master periods");
    a_cal_length: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(busy) && $past(state_ff) == ST_CAL |->
        $past(busy_len_ff) == 22'(int'($past(len_ff)) * MCLK_DIV - 1))
        else $error("calibration length wrong");
    a_offset_kept: assert property (@(posedge clock) disable iff (sys_rst)
        !(state_ff == ST_CAL && cal_kind_ff == CAL_OFFSET) |=> $stable(offset_ff))
        else $error("offset correction changed outside offset calibration");
    a_offset_load: assert property (@(posedge clock) disable iff (sys_rst)
        state_ff == ST_CAL && cal_kind_ff == CAL_OFFSET && nxt_state == ST_IDLE |=>
        offset_ff == $past(adc_code))
        else $error("offset not captured after offset calibration");
    a_busy_rise: assert property (@(posedge clock) disable iff (sys_rst)
        cal_pend_ff && cs_rise |-> ##[1:3] busy)
        else $error("busy late after chip select rise");
    a_result_lead: assert property (@(posedge clock) disable iff (sys_rst)
        res_valid |=> busy [*8] ##1 busy [*5] ##1 !busy)
        else $error("busy fell too soon after result");
    a_busy_hold: assert property (@(posedge clock) disable iff (sys_rst)
        busy == (state_ff != ST_IDLE))
        else $error("busy does not match sequence activity");
    a_no_overflow: assert property (@(posedge clock) disable iff (sys_rst)
        trig_fall && !res_ready && !cal_start && state_ff == ST_IDLE |=> state_ff == ST_IDLE)
        else $error("conversion started into a full buffer");

    c_conversion: cover property (@(posedge clock) disable iff (sys_rst)
        res_valid ##14 !busy);
    c_offset_cal: cover property (@(posedge clock) disable iff (sys_rst)
        state_ff == ST_CAL && cal_kind_ff == CAL_OFFSET ##1 state_ff == ST_IDLE);
    c_full_buffer: cover property (@(posedge clock) disable iff (sys_rst) !res_ready);
    c_read: cover property (@(posedge clock) disable iff (sys_rst) pop);
endmodule
`default_nettype wire

// ==== host_model.sv ====
// host side model: parallel port master and conversion trigger pin
// assumes the sequencer passes every pin through its own synchronisers
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic clock,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic upper_byte_select,
    output logic [15:0] db_in,
    output logic sample_trigger_n,
    input wire logic [15:0] db_out,
    input wire logic db_oe_n
);
    // idle levels at time zero: strobes high, nothing selected
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        upper_byte_select = 1'b0;
        db_in = 16'hffff;
        sample_trigger_n = 1'b1;
    end

    // control write, strobes held long enough to cross the synchronisers
    task automatic write_word(input logic [15:0] w);
        @(posedge clock);
        cs_n <= 1'b0;
        db_in <= w;
        repeat (2) @(posedge clock);
        wr_n <= 1'b0;
        repeat (4) @(posedge clock);
        wr_n <= 1'b1;
        repeat (4) @(posedge clock);
        cs_n <= 1'b1; // this rise launches an armed calibration
        db_in <= ~w; // released bus must not keep showing the word
    endtask

    // one byte or word read; ok low if the port never answered
    task automatic read_byte(input logic ubs, output logic [15:0] d, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clock);
        cs_n <= 1'b0;
        upper_byte_select <= ubs;
        @(posedge clock);
        rd_n <= 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge clock);
            #1 ok = (db_oe_n === 1'b0);
        end
        d = db_out;
        @(posedge clock);
        rd_n <= 1'b1;
        for (n = 0; n < 20 && db_oe_n !== 1'b1; n++)
        begin
            @(posedge clock);
            #1;
        end
        ok = ok && (db_oe_n === 1'b1);
        @(posedge clock);
        cs_n <= 1'b1; // chip select kept low until the pop has been seen
        repeat (3) @(posedge clock);
    endtask

    // conversion start pulse, wide enough for the synchroniser
    task automatic trigger();
        @(posedge clock);
        sample_trigger_n <= 1'b0;
        repeat (3) @(posedge clock);
        sample_trigger_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ==== tb_adc_sequencer.sv ====
// self-checking bench for the conversion and calibration sequencer
// assumes the host model drives the port and adc_code is driven here
`timescale 1ns/10ps
`default_nettype none
`define CHECK(act, want) \
    begin samples_checked++; if ((act) !== (want)) begin error_cnt++; \
    $display("ERROR %0t got %h expected %h", $time, act, want); end end
module tb_adc_sequencer
    import adc_seq_pkg::*;
;
    // shortened calibration lengths keep the run short
    localparam logic [16:0] FULL_LEN = 17'h00003;
    localparam logic [16:0] DAC_LEN = 17'h00004;
    localparam logic [16:0] OFF_LEN = 17'h00005;
    localparam logic [11:0] OFF_CODE = 12'h010;
    logic clock;
    logic sys_rst;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic upper_byte_select;
    logic [15:0] db_in;
    logic sample_trigger_n;
    logic [15:0] db_out;
    logic db_oe_n;
    logic busy;
    logic [2:0] channel_select;
    logic [11:0] adc_code;
    int error_cnt = 0;
    int samples_checked = 0;
    int run_cnt = 0;
    int last_run = 0;
    int rises = 0;
    logic [15:0] expq[$];

    adc_sequencer #(
        .CAL_FULL_LEN(FULL_LEN),
        .CAL_DAC_FS_LEN(DAC_LEN),
        .CAL_OFFSET_LEN(OFF_LEN)
    ) adc_sequencer_i (
        .clock(clock),
        .sys_rst(sys_rst),
        .sample_trigger_n(sample_trigger_n),
        .cs_n(cs_n),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .upper_byte_select(upper_byte_select),
        .db_in(db_in),
        .db_out(db_out),
        .db_oe_n(db_oe_n),
        .busy(busy),
        .channel_select(channel_select),
        .adc_code(adc_code)
    );

    host_model host_model_i (
        .clock(clock),
        .cs_n(cs_n),
        .rd_n(rd_n),
        .wr_n(wr_n),
        .upper_byte_select(upper_byte_select),
        .db_in(db_in),
        .sample_trigger_n(sample_trigger_n),
        .db_out(db_out),
        .db_oe_n(db_oe_n)
    );

    // 100 MHz clock
    initial clock = 1'b0;
    always #5 clock = ~clock;

    // busy run length in cycles, and count of completed runs
    always @(posedge clock)
    begin
        if (busy === 1'b1)
            run_cnt <= run_cnt + 1;
        else if (run_cnt != 0)
        begin
            last_run <= run_cnt;
            rises <= rises + 1;
            run_cnt <= 0;
        end
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // the fall of busy is the only completion signal the host gets
    task automatic wait_done();
        int r0;
        int t;
        r0 = rises;
        for (t = 0; t < 2000 && rises == r0; t++)
            @(posedge clock);
        if (rises == r0)
        begin
            error_cnt++;
            $display("ERROR %0t busy never fell", $time);
            report_and_stop();
        end
        #1;
    endtask

    // calibration: busy rise after chip select, then its exact length
    task automatic check_cal(input logic [1:0] kind, input logic [16:0] len,
                             input logic [11:0] code);
        int n;
        @(posedge clock);
        adc_code <= code;
        host_model_i.write_word({10'h000, 1'b1, kind, 1'b0, kind});
        for (n = 0; n < 100 && busy !== 1'b1; n++)
        begin
            @(posedge clock);
            #1;
        end
        `CHECK(channel_select, {1'b0, kind})
        `CHECK(n <= BUSY_RISE_CYC, 1'b1)
        wait_done();
        `CHECK(last_run, int'(len) * MCLK_DIV)
    endtask

    // fill the buffer by conversions until a trigger is refused
    task automatic fill_fifo();
        int r0;
        host_model_i.write_word(16'h0005); // channel 5, nothing armed
        for (int i = 0; i <= RES_DEPTH; i++)
        begin
            @(posedge clock);
            adc_code <= 12'h100 + 12'(i);
            r0 = rises;
            host_model_i.trigger();
            if (i < RES_DEPTH)
            begin
                // a second trigger mid-conversion must leave no trace
                if (i == 0)
                begin
                    repeat (50) @(posedge clock);
                    host_model_i.trigger();
                end
                wait_done();
                `CHECK(last_run, int'(CONV_MCLK) * MCLK_DIV + HALF_CYC)
                expq.push_back({1'b0, 3'h5, 12'h100 + 12'(i) - OFF_CODE});
            end
            else
            begin
                repeat (600) @(posedge clock);
                `CHECK(rises + run_cnt, r0)
            end
        end
    endtask

    // drain: high byte then low byte of each word, in order
    task automatic drain_fifo();
        logic [15:0] hi;
        logic [15:0] lo;
        logic [15:0] exp_w;
        logic ok1;
        logic ok2;
        while (expq.size() > 0)
        begin
            exp_w = expq.pop_front();
            host_model_i.read_byte(1'b1, hi, ok1);
            host_model_i.read_byte(1'b0, lo, ok2);
            `CHECK({ok1, ok2}, 2'b11)
            `CHECK(hi, {8'h00, exp_w[15:8]})
            `CHECK(lo, exp_w)
        end
    endtask

    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        adc_code = 12'h000;
        // reset is seen high at five rising edges, released on the fifth
        repeat (4) @(posedge clock);
        #1;
        `CHECK(busy, 1'b0)
        `CHECK(db_oe_n, 1'b1)
        `CHECK(channel_select, 3'h0)
        @(posedge clock);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clock);
        check_cal(2'h1, FULL_LEN, 12'h3a5);
        check_cal(2'h2, DAC_LEN, 12'h2c7);
        check_cal(2'h3, OFF_LEN, OFF_CODE);
        fill_fifo();
        drain_fifo();
        report_and_stop();
    end
endmodule
`default_nettype wire
